// >>> design/aims_consts.svh
`ifndef AIMS_CONSTS_SVH
`define AIMS_CONSTS_SVH

// ----------------------------------------------------------------
// Clocking
// ----------------------------------------------------------------
`define AIMS_SYS_CLK_HZ   25000000
`define AIMS_CONV_CLK_HZ  5000000
`define AIMS_CONV_DIV     (`AIMS_SYS_CLK_HZ / `AIMS_CONV_CLK_HZ)
`define AIMS_DIV_LAST     (3'(`AIMS_CONV_DIV - 1))
// Converter clocks per channel, one of them uncertainty
`define AIMS_CLKS_PER_CH  (9 * 2)
`define AIMS_TICK_LAST    (5'(`AIMS_CLKS_PER_CH - 2))

// ----------------------------------------------------------------
// Configuration data bus fields
// ----------------------------------------------------------------
`define AIMS_F_INH        7
`define AIMS_F_DIFFERENTIAL_SELECT       6
`define AIMS_F_BIP        5
`define AIMS_F_ADR_HI     2
`define AIMS_F_ADR_LO     0

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AIMS_OFS_STATUS   4'h0
`define AIMS_OFS_MASK     4'h4
`define AIMS_OFS_STATE    4'h8
`define AIMS_OFS_CTRL     4'hC
`define AIMS_EV_DONE      0
`define AIMS_EV_REFUSED   1
`define AIMS_EV_CFGWR     2
`define AIMS_RESP_OKAY    2'h0
`define AIMS_RESP_SLVERR  2'h2
`define AIMS_CTRL_RST     1'h1
`define AIMS_MASK_RST     3'h0

`endif

// >>> design/aims_pkg.sv
package aims_pkg;

  typedef enum logic [0:0] {
    AIMS_IDLE = 1'b0,
    AIMS_CONV = 1'b1
  } aims_state_t;

  // Per-location conversion type
  typedef struct packed {
    logic differential_select;
    logic bipolar_select;
  } aims_sel_t;

  // Host strobe bus, after synchronising
  typedef struct packed {
    logic       cs_n;
    logic       wr_n;
    logic       rd_n;
    logic       mode_open;
    logic [7:0] d;
  } aims_pins_t;

  typedef struct packed {
    aims_state_t          st;
    logic                 busy;
    logic [2:0]           div;
    logic [4:0]           tcnt;
    logic [2:0]           cur;
    logic [9:0]           cyc;
    logic [7:0]           en;
    logic [7:0]           run_en;
    aims_sel_t [7:0]      stg;
    aims_sel_t [7:0]      act;
    logic [3:0]           pol;
    logic [7:0][7:0]      hold;
    logic [7:0][7:0]      ram;
    logic [2:0]           ptr;
    logic [7:0]           dout;
    logic                 doe;
    logic                 wr_p;
    logic                 rd_p;
    logic [2:0]           status;
    logic [2:0]           mask;
    logic                 ctl_en;
    logic                 irq;
    logic                 aw_have;
    logic                 w_have;
    logic [7:0]           aw_addr;
    logic [31:0]          wdata;
    logic [3:0]           wstrb;
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
  } aims_st_t;

endpackage

// >>> design/aims_sync.sv
`timescale 1ns/10ps
module aims_sync #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Data
  input  wire logic [W-1:0]   d,
  output logic      [W-1:0]   q
);

  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Two flops per bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_q[gi] <= INIT[gi];
          q[gi]      <= INIT[gi];
        end else begin
          meta_q[gi] <= d[gi];
          q[gi]      <= meta_q[gi];
        end
      end
    end
  endgenerate

endmodule

// >>> design/aims_conv.sv
`timescale 1ns/10ps
module aims_conv (
  // Held codes
  input  wire logic [7:0] pos,
  input  wire logic [7:0] neg,
  // Conversion type
  input  wire logic       differential_select,
  input  wire logic       bipolar_select,
  // Result
  output logic      [7:0] res
);

  logic [8:0] delta;

  always_comb begin
    delta = {1'b0, pos} - {1'b0, neg};
    if (!differential_select) begin
      res = bipolar_select ? (pos ^ 8'h80) : pos;
    end else if (!bipolar_select) begin
      // Unipolar difference clamps at zero
      res = delta[8] ? 8'h00 : delta[7:0];
    end else begin
      res = delta[8:1] ^ 8'h80;
    end
  end

endmodule

// >>> design/aims_top.sv
`timescale 1ns/10ps
`include "aims_consts.svh"
module aims_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Host strobe bus
  input  wire logic        cs_n,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic        mode_open,
  input  wire logic [7:0]  d_in,
  output logic [7:0]       d_out,
  output logic             d_oe,
  output logic             busy,
  // Digitised analog inputs, channel k in bits 8k+7..8k
  input  wire logic [63:0] ain_code,
  // Interrupt
  output logic             irq
);

  aims_pkg::aims_st_t   s;
  aims_pkg::aims_st_t   n;
  aims_pkg::aims_pins_t pins_raw;
  aims_pkg::aims_pins_t pins;
  logic [63:0]          ain_s;
  logic [7:0]           pos_c;
  logic [7:0]           neg_c;
  logic [7:0]           res_c;
  logic                 differential_select_c;
  logic                 bip_c;
  logic                 sel;
  logic                 wr_fall;
  logic                 wr_rise;
  logic                 rd_fall;
  logic                 rd_rise;
  logic                 tick;
  logic                 start;
  logic [2:0]           adr;
  logic [2:0]           nx;
  logic [7:0]           en_w;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign pins_raw = '{cs_n: cs_n, wr_n: wr_n, rd_n: rd_n,
                      mode_open: mode_open, d: d_in};

  aims_sync #(
    .W    ($bits(aims_pkg::aims_pins_t)),
    .INIT (12'hE00)
  ) u_sync_pins (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins)
  );

  aims_sync #(
    .W    (64),
    .INIT (64'h0)
  ) u_sync_ain (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (ain_code),
    .q       (ain_s)
  );

  // ----------------------------------------------------------------
  // Channel converter
  // ----------------------------------------------------------------
  // Pair polarity is read live so a swap needs no extra conversion
  always_comb begin
    differential_select_c = s.act[s.cur].differential_select;
    bip_c  = s.act[s.cur].bipolar_select;
    if (differential_select_c) begin
      pos_c = s.pol[s.cur[2:1]] ? s.hold[{s.cur[2:1], 1'b1}]
                                : s.hold[{s.cur[2:1], 1'b0}];
      neg_c = s.pol[s.cur[2:1]] ? s.hold[{s.cur[2:1], 1'b0}]
                                : s.hold[{s.cur[2:1], 1'b1}];
    end else begin
      pos_c = s.hold[s.cur];
      neg_c = 8'h00;
    end
  end

  aims_conv u_conv (
    .pos  (pos_c),
    .neg  (neg_c),
    .differential_select (differential_select_c),
    .bipolar_select  (bip_c),
    .res  (res_c)
  );

  // First enabled location at or after a start point, cyclic
  function automatic logic [2:0] next_en(input logic [7:0] en,
                                         input logic [2:0] from,
                                         input logic       incl);
    logic [2:0] c;
    next_en = from;
    for (int k = 7; k >= 0; k--) begin
      c = from + 3'(k) + {2'b00, ~incl};
      if (en[c]) begin
        next_en = c;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  // config path live only with mode input open
  assign sel     = !pins.cs_n && s.ctl_en && pins.mode_open;
  assign wr_fall = sel && s.wr_p && !pins.wr_n;
  assign wr_rise = sel && !s.wr_p && pins.wr_n;
  assign rd_fall = sel && s.rd_p && !pins.rd_n && s.busy;
  assign rd_rise = s.doe && pins.rd_n;
  assign tick    = (s.div == `AIMS_DIV_LAST);
  assign adr     = pins.d[`AIMS_F_ADR_HI:`AIMS_F_ADR_LO];
  assign start   = wr_rise && !pins.d[`AIMS_F_INH];
  assign nx      = next_en(s.run_en, s.cur, 1'b0);

  // Enable set as it stands after this write
  always_comb begin
    en_w = s.en;
    if (pins.d[`AIMS_F_DIFFERENTIAL_SELECT]) begin
      en_w[{adr[2:1], 1'b0}] = 1'b1;
      en_w[{adr[2:1], 1'b1}] = 1'b0;
    end else begin
      en_w[adr] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    ev  = 3'h0;
    clr = 3'h0;
    n   = s;
    n.wr_p = pins.wr_n;
    n.rd_p = pins.rd_n;
    n.div  = tick ? 3'h0 : s.div + 3'h1;

    // simultaneous sample on falling write strobe
    if (wr_fall && s.st == aims_pkg::AIMS_IDLE) begin
      n.hold = ain_s;
    end

    // entry captured on rising write strobe
    if (wr_rise) begin
      ev[`AIMS_EV_CFGWR] = 1'b1;
      n.en = en_w;
      if (pins.d[`AIMS_F_DIFFERENTIAL_SELECT]) begin
        n.stg[{adr[2:1], 1'b0}] = '{differential_select: 1'b1,
                                     bipolar_select: pins.d[`AIMS_F_BIP]};
        // polarity takes effect on this write
        n.pol[adr[2:1]] = adr[0];
      end else begin
        n.stg[adr] = '{differential_select: 1'b0, bipolar_select: pins.d[`AIMS_F_BIP]};
      end
      // inhibited write stores the entry and also moves the read pointer
      if (pins.d[`AIMS_F_INH]) begin
        n.ptr = adr;
      end
    end

    if (start) begin
      if (s.st == aims_pkg::AIMS_IDLE && en_w != 8'h00) begin
        n.st     = aims_pkg::AIMS_CONV;
        n.busy   = 1'b0;
        n.run_en = en_w;
        n.cur    = next_en(en_w, 3'h0, 1'b1);
        n.tcnt   = 5'h0;
        n.cyc    = 10'h0;
        n.doe    = 1'b0;
      end else begin
        ev[`AIMS_EV_REFUSED] = 1'b1;
      end
    end

    if (s.st == aims_pkg::AIMS_CONV) begin
      n.cyc = s.cyc + 10'h1;
      if (tick) begin
        n.tcnt = s.tcnt + 5'h1;
        if (s.tcnt == `AIMS_TICK_LAST) begin
          n.ram[s.cur] = res_c;
          n.tcnt       = 5'h0;
          n.cur        = nx;
          // busy returns only after the last store
          if (nx <= s.cur) begin
            n.st   = aims_pkg::AIMS_IDLE;
            n.busy = 1'b1;
            // Selection latency: new types apply next time
            n.act  = s.stg;
            // reads begin at the lowest configured channel
            n.ptr  = next_en(s.run_en, 3'h0, 1'b1);
            ev[`AIMS_EV_DONE] = 1'b1;
          end
        end
      end
    end

    // each read strobe while busy is high (idle) drives one stored result
    if (rd_fall) begin
      n.dout = s.ram[s.ptr];
      n.doe  = 1'b1;
    end
    if (rd_rise) begin
      n.doe = 1'b0;
      n.ptr = next_en(s.en, s.ptr, 1'b0);
    end
    if (pins.cs_n) begin
      n.doe = 1'b0;
    end

    // AXI write
    if (s_axi_awvalid && s.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = `AIMS_RESP_OKAY;
      if (s.aw_addr[7:4] != 4'h0) begin
        n.bresp = `AIMS_RESP_SLVERR;
      end else if (s.wstrb[0]) begin
        case (s.aw_addr[3:0] & 4'hC)
          `AIMS_OFS_MASK: n.mask   = s.wdata[2:0];
          `AIMS_OFS_CTRL: n.ctl_en = s.wdata[0];
          default: ;
        endcase
      end
    end
    n.awready = !n.aw_have;
    n.wready  = !n.w_have;

    // AXI read
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `AIMS_RESP_OKAY;
      n.rdata  = 32'h0;
      if (s_axi_araddr[7:4] != 4'h0) begin
        n.rresp = `AIMS_RESP_SLVERR;
      end else begin
        case (s_axi_araddr[3:0] & 4'hC)
          `AIMS_OFS_STATUS: begin
            n.rdata[2:0] = s.status;
            clr          = s.status;
          end
          `AIMS_OFS_MASK:  n.rdata[2:0] = s.mask;
          `AIMS_OFS_STATE: n.rdata[15:0] = {s.en, 3'h0, s.ptr,
                                           1'b0, s.busy};
          `AIMS_OFS_CTRL:  n.rdata[0] = s.ctl_en;
          default: ;
        endcase
      end
    end
    n.arready = !n.rvalid;

    // Event set wins over read clear
    n.status = (s.status & ~clr) | ev;
    n.irq    = |(n.status & n.mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s        <= '0;
      s.busy   <= 1'b1;
      s.wr_p   <= 1'b1;
      s.rd_p   <= 1'b1;
      s.ctl_en <= `AIMS_CTRL_RST;
      s.mask   <= `AIMS_MASK_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign d_out         = s.dout;
  assign d_oe          = s.doe;
  assign busy          = s.busy;
  assign irq           = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic [1:0] pair_w;
  logic       lsb_w;
  assign pair_w = adr[2:1];
  assign lsb_w  = adr[0];

  sequence seq_start;
    start && s.st == aims_pkg::AIMS_IDLE && en_w != 8'h00;
  endsequence
  sequence seq_end;
    s.st == aims_pkg::AIMS_CONV ##1 s.st == aims_pkg::AIMS_IDLE;
  endsequence

  a_conv_time_bound: assert property (
    s.cyc <= 10'(`AIMS_CLKS_PER_CH * `AIMS_CONV_DIV
                 * $countones(s.run_en)))
    else $error("conversion ran past its clock budget");
  a_pair_polarity: assert property (
    wr_rise && pins.d[`AIMS_F_DIFFERENTIAL_SELECT] |=> s.pol[$past(pair_w)]
      == $past(lsb_w))
    else $error("pair polarity not taken from address lsb");
  a_start_busy_low: assert property (
    seq_start |=> !s.busy ##1 !s.busy)
    else $error("starting write did not drop busy");
  a_done_store: assert property (
    seq_end |-> s.busy && s.ram[$past(s.cur)] == $past(res_c))
    else $error("busy rose before result stored");
  a_first_read: assert property (
    seq_end |-> s.ptr == next_en(s.run_en, 3'h0, 1'b1))
    else $error("read pointer not at lowest channel");
  a_read_drive: assert property (
    rd_fall |=> s.doe && s.dout == $past(s.ram[s.ptr]))
    else $error("read strobe did not drive stored result");
  a_read_wrap: assert property (
    rd_rise && s.en != 8'h00 |=> s.en[s.ptr])
    else $error("read pointer left configured channels");
  a_mode_gate: assert property (
    !pins.mode_open && s.st == aims_pkg::AIMS_IDLE |=> s.busy)
    else $error("conversion started with mode input driven");
  a_sample_hold: assert property (
    wr_fall && s.st == aims_pkg::AIMS_IDLE |=> s.hold == $past(ain_s))
    else $error("inputs not sampled together");
  a_inhibit_idle: assert property (
    wr_rise && pins.d[`AIMS_F_INH] && s.busy |=> s.busy[*2])
    else $error("inhibited write started a conversion");
  a_busy_state: assert property (
    s.busy == (s.st == aims_pkg::AIMS_IDLE))
    else $error("busy disagrees with sequencer state");

endmodule

// >>> verif/aims_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host processor on the strobe bus
// ----------------------------------------
// Strobes are held well past the two-flop synchronisers
module aims_host_model (
  // Clock
  input  wire logic       aclk,
  // Strobe bus
  output logic            cs_n,
  output logic            wr_n,
  output logic            rd_n,
  output logic            mode_open,
  output logic [7:0]      d_in,
  // Device answers
  input  wire logic [7:0] d_out,
  input  wire logic       d_oe,
  input  wire logic       busy
);
  initial begin
    cs_n      = 1'h1;
    wr_n      = 1'h1;
    rd_n      = 1'h1;
    mode_open = 1'h1;
    d_in      = 8'hA5;
  end

  task automatic set_mode(input logic open);
    @(posedge aclk);
    mode_open <= open;
  endtask

  task automatic write_byte(input logic [7:0] v);
    @(posedge aclk);
    cs_n <= 1'h0;
    d_in <= v;
    @(posedge aclk);
    wr_n <= 1'h0;
    repeat (8) @(posedge aclk);
    wr_n <= 1'h1;
    repeat (5) @(posedge aclk);
    cs_n <= 1'h1;
    // No pull on the bus, so show the inverse once released
    d_in <= ~v;
    repeat (4) @(posedge aclk);
  endtask

  // reads once busy is high, or after 500 cycles of waiting
  task automatic read_byte(output logic [7:0] v, output logic oe);
    int n;
    n = 0;
    while (busy !== 1'h1 && n < 500) begin
      @(posedge aclk);
      n++;
    end
    @(posedge aclk);
    cs_n <= 1'h0;
    @(posedge aclk);
    rd_n <= 1'h0;
    repeat (6) @(posedge aclk);
    v  = d_out;
    oe = d_oe;
    rd_n <= 1'h1;
    repeat (5) @(posedge aclk);
    cs_n <= 1'h1;
    repeat (4) @(posedge aclk);
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/10ps
`include "aims_consts.svh"
module testbench;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  logic [63:0] ain_code = 64'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        cs_n, wr_n, rd_n, mode_open, d_oe, busy, irq;
  logic [7:0]  d_in, d_out;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  aims_top aims_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cs_n, .wr_n, .rd_n,
    .mode_open, .d_in, .d_out, .d_oe, .busy, .ain_code, .irq);

  aims_host_model aims_host_model_inst (.aclk, .cs_n, .wr_n, .rd_n,
    .mode_open, .d_in, .d_out, .d_oe, .busy);

  always #20 aclk = ~aclk;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic end_of_test();
    $display("compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Whole run needs some 1750 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        input logic [3:0] st, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    // Only the run's own timeout ends a missing answer
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  task automatic rd_chk(input logic [7:0] e);
    logic [7:0] v;
    logic       oe;
    aims_host_model_inst.read_byte(v, oe);
    chk("d_oe", 32'h1, 32'(oe));
    chk("d_out", 32'(e), 32'(v));
  endtask

  // Start write, then time the busy-low span
  task automatic convert(input logic [7:0] b, input int nch);
    int n;
    int lim;
    n = 0;
    lim = `AIMS_CLKS_PER_CH * `AIMS_CONV_DIV * nch;
    repeat (20) @(posedge aclk);
    fork
      aims_host_model_inst.write_byte(b);
      begin
        while (busy !== 1'h0 && n < 100) begin
          @(posedge aclk);
          n++;
        end
        n = 0;
        while (busy !== 1'h1 && n < 400) begin
          @(posedge aclk);
          n++;
        end
      end
    join
    chk("busy_span_ok", 32'h1, 32'(n <= lim && n >= lim - 2 * nch * 5));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk("busy", 32'h1, 32'(busy));
    chk("d_oe", 32'h0, 32'(d_oe));
    chk("irq", 32'h0, 32'(irq));
    axi_rd({4'h0, `AIMS_OFS_CTRL}, r, `AIMS_RESP_OKAY);
    chk("ctrl", 32'h1, r);
    axi_rd({4'h0, `AIMS_OFS_MASK}, r, `AIMS_RESP_OKAY);
    chk("mask", 32'h0, r);
    axi_rd(8'h10, r, `AIMS_RESP_SLVERR);
    axi_wr(8'h40, 32'hFF, 4'hF, `AIMS_RESP_SLVERR);
    ain_code <= 64'h0000_0000_2211_3050;
    aims_host_model_inst.write_byte(8'hC0);
    aims_host_model_inst.write_byte(8'h82);
    aims_host_model_inst.write_byte(8'hA3);
    chk("busy", 32'h1, 32'(busy));
    // Dummy run lets the new selects take effect
    convert(8'h40, 3);
    axi_wr({4'h0, `AIMS_OFS_MASK}, 32'h1, 4'hF, `AIMS_RESP_OKAY);
    // Lane zero off: the write is answered but dropped
    axi_wr({4'h0, `AIMS_OFS_MASK}, 32'h6, 4'hE, `AIMS_RESP_OKAY);
    axi_rd({4'h0, `AIMS_OFS_MASK}, r, `AIMS_RESP_OKAY);
    chk("mask", 32'h1, r);
    axi_rd({4'h0, `AIMS_OFS_STATUS}, r, `AIMS_RESP_OKAY);
    convert(8'h40, 3);
    chk("irq", 32'h1, 32'(irq));
    rd_chk(8'h20);
    rd_chk(8'h11);
    rd_chk(8'hA2);
    rd_chk(8'h20);
    axi_rd({4'h0, `AIMS_OFS_STATUS}, r, `AIMS_RESP_OKAY);
    chk("status", 32'h1, r & 32'h3);
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, 32'(irq));
    aims_host_model_inst.set_mode(1'h0);
    aims_host_model_inst.write_byte(8'h04);
    chk("busy", 32'h1, 32'(busy));
    aims_host_model_inst.set_mode(1'h1);
    // Host interface switched off: strobes must be ignored
    axi_wr({4'h0, `AIMS_OFS_CTRL}, 32'h0, 4'hF, `AIMS_RESP_OKAY);
    aims_host_model_inst.write_byte(8'h04);
    chk("busy", 32'h1, 32'(busy));
    axi_wr({4'h0, `AIMS_OFS_CTRL}, 32'h1, 4'hF, `AIMS_RESP_OKAY);
    axi_rd({4'h0, `AIMS_OFS_STATE}, r, `AIMS_RESP_OKAY);
    chk("state", 32'h0D01, r & 32'hFF01);
    axi_wr({4'h0, `AIMS_OFS_MASK}, 32'h2, 4'hF, `AIMS_RESP_OKAY);
    ain_code <= 64'h0000_0000_7F05_7030;
    fork
      convert(8'h41, 3);
      begin
        // Inputs move while the strobe is still low
        repeat (26) @(posedge aclk);
        ain_code <= 64'h1234_5678_9ABC_DEF0;
        // Second start in mid-conversion is refused
        repeat (60) @(posedge aclk);
        aims_host_model_inst.write_byte(8'h41);
      end
    join
    chk("irq", 32'h1, 32'(irq));
    rd_chk(8'h40);
    rd_chk(8'h05);
    rd_chk(8'hFF);
    axi_rd({4'h0, `AIMS_OFS_STATUS}, r, `AIMS_RESP_OKAY);
    chk("status", 32'h3, r & 32'h3);
    // Differential bipolar entry, live after one dummy run
    aims_host_model_inst.write_byte(8'hE0);
    convert(8'h60, 3);
    convert(8'h60, 3);
    rd_chk(8'h89);
    end_of_test();
  end
endmodule
